// ==== hdl/dic_pkg.sv ====
// package: constants and types for the digital input conditioner
package dic_pkg;
	localparam int unsigned CLK_HZ          = 125000000;
	localparam int unsigned NUM_INPUTS      = 8;
	localparam int unsigned NUM_RELAYS      = 5;
	localparam int unsigned VOLT_W          = 19;	// millivolts, 0..275000
	localparam int unsigned THR_W           = 11;	// decivolts, 0..2000
	localparam int unsigned DELAY_W         = 21;	// milliseconds, 0..1800000
	localparam int unsigned COUNT_W         = 32;
	localparam int unsigned SCAN_MS         = 5;
	localparam int unsigned SCAN_CYCLES     = CLK_HZ / 1000 * SCAN_MS;
	localparam int unsigned AC_EXTRA_MS     = 30;
	localparam int unsigned MV_PER_DV       = 100;
	localparam int unsigned AC_REL_DIV      = 10;
	localparam logic [THR_W-1:0]   ACT_THR_RST = 11'h370;	// 88.0 V
	localparam logic [THR_W-1:0]   REL_THR_RST = 11'h258;	// 60.0 V
	localparam logic [DELAY_W-1:0] DELAY_RST   = 21'h000000;
	localparam logic [DELAY_W-1:0] SCAN_MS_D   = 21'h000005;
	localparam logic [DELAY_W-1:0] AC_EXTRA_D  = 21'h00001e;
	typedef logic [VOLT_W-1:0]  dic_volt_t;
	typedef logic [THR_W-1:0]   dic_thr_t;
	typedef logic [DELAY_W-1:0] dic_delay_t;
	typedef logic [COUNT_W-1:0] dic_count_t;
endpackage : dic_pkg

// ==== hdl/dic_channel.sv ====
// one conditioned input channel: thresholds, delays, counter
`timescale 1ns/100ps
`default_nettype none
module dic_channel
	import dic_pkg::*;
(
	input  wire logic      clock,       // system clock
	input  wire logic      reset,       // sync reset, high
	input  wire logic      scan,        // one pulse per scan
	input  wire dic_volt_t volt,        // measured millivolts
	input  wire logic      nc_pol,      // 1 = normally closed
	input  wire logic      ac_mode,     // alternating supply option
	input  wire dic_thr_t  act_thr,     // activation, decivolts
	input  wire dic_thr_t  rel_thr,     // release, decivolts
	input  wire dic_delay_t act_dly,    // activation delay, ms
	input  wire dic_delay_t drop_dly,   // drop-off delay, ms
	input  wire logic      clr_count,   // clear counter pulse
	output var  logic      status_ff,   // conditioned status
	output var  dic_count_t count_ff,   // rising transition count
	output var  dic_volt_t volt_ff      // reported voltage
);
	logic       raw_ff;
	dic_delay_t elapsed_ff;
	logic [VOLT_W+6:0] act_mv;
	logic [VOLT_W+6:0] rel_mv;
	logic       nxt_raw;
	logic       target;
	dic_delay_t hold;

	always_comb
	begin
		act_mv = (VOLT_W+7)'(act_thr) * (VOLT_W+7)'(MV_PER_DV);
		rel_mv = ac_mode ? act_mv / (VOLT_W+7)'(AC_REL_DIV)
			: (VOLT_W+7)'(rel_thr) * (VOLT_W+7)'(MV_PER_DV);
		nxt_raw = raw_ff;
		if ((VOLT_W+7)'(volt) > act_mv)
			nxt_raw = 1'b1;
		else if ((VOLT_W+7)'(volt) < rel_mv)
			nxt_raw = 1'b0;
		target = nxt_raw ^ nc_pol;
		hold = target ? act_dly
			: drop_dly + (ac_mode ? AC_EXTRA_D : DELAY_RST);
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			raw_ff <= 1'b0;
		else if (scan)
			raw_ff <= nxt_raw;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			status_ff  <= 1'b0;
			elapsed_ff <= DELAY_RST;
		end
		else if (scan)
		begin
			if (target == status_ff)
				elapsed_ff <= DELAY_RST;
			else if (elapsed_ff + SCAN_MS_D > hold)
			begin
				status_ff  <= target;
				elapsed_ff <= DELAY_RST;
			end
			else
				elapsed_ff <= elapsed_ff + SCAN_MS_D;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset || clr_count)
			count_ff <= '0;
		else if (scan && target && !status_ff && (elapsed_ff + SCAN_MS_D > hold))
			count_ff <= count_ff + 32'h1;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			volt_ff <= '0;
		else if (scan)
			volt_ff <= volt;
	end

	rise_count_a: assert property (@(posedge clock) disable iff (reset)
		$rose(status_ff) && !$past(clr_count) |-> count_ff == $past(count_ff) + 32'h1)
		else $error("counter missed a rising status");
	clr_count_a: assert property (@(posedge clock) disable iff (reset)
		clr_count |=> count_ff == '0)
		else $error("counter not cleared");
	scan_only_a: assert property (@(posedge clock) disable iff (reset)
		!$past(scan) |-> $stable(status_ff))
		else $error("status changed off scan");
	act_delay_a: assert property (@(posedge clock) disable iff (reset)
		$rose(status_ff) |-> $past(elapsed_ff) + SCAN_MS_D > $past(act_dly))
		else $error("activation delay cut short");
	drop_delay_a: assert property (@(posedge clock) disable iff (reset)
		$fell(status_ff) |-> $past(elapsed_ff) + SCAN_MS_D > $past(drop_dly)
			+ ($past(ac_mode) ? AC_EXTRA_D : DELAY_RST))
		else $error("drop-off delay cut short");
	hyst_hold_a: assert property (@(posedge clock) disable iff (reset)
		scan && !$past(ac_mode) && !ac_mode && volt * 1 <= act_thr * MV_PER_DV
			&& volt >= rel_thr * MV_PER_DV |=> raw_ff == $past(raw_ff))
		else $error("raw state moved inside band");
	volt_rep_a: assert property (@(posedge clock) disable iff (reset)
		scan |=> volt_ff == $past(volt))
		else $error("voltage not reported");
	pol_a: assert property (@(posedge clock) disable iff (reset)
		scan && volt > act_thr * MV_PER_DV
			&& (nc_pol ? (drop_dly == DELAY_RST && !ac_mode) : (act_dly == DELAY_RST))
			|=> status_ff == !$past(nc_pol))
		else $error("polarity result wrong");
	rise_c: cover property (@(posedge clock) $rose(status_ff));
	fall_c: cover property (@(posedge clock) $fell(status_ff) && ac_mode);
	clr_c: cover property (@(posedge clock) clr_count && count_ff != '0);
endmodule : dic_channel
`default_nettype wire

// ==== hdl/dic_top.sv ====
// top: eight-input conditioner and five-relay output card
`timescale 1ns/100ps
`default_nettype none
module dic_top
#(
	parameter int unsigned SCAN_LEN = dic_pkg::SCAN_CYCLES	// clocks per scan, 5 ms by default
)
(
	input  wire logic                                          clock,        // 125 MHz
	input  wire logic                                          reset,        // sync, high
	input  wire dic_pkg::dic_volt_t [dic_pkg::NUM_INPUTS-1:0]  volt_in,      // digitised mV
	input  wire logic [dic_pkg::NUM_INPUTS-1:0]                nc_pol,       // polarity
	input  wire logic [dic_pkg::NUM_INPUTS-1:0]                ac_mode,      // ac option
	input  wire dic_pkg::dic_thr_t [dic_pkg::NUM_INPUTS-1:0]   act_thr,      // decivolts
	input  wire dic_pkg::dic_thr_t [dic_pkg::NUM_INPUTS-1:0]   rel_thr,      // decivolts
	input  wire dic_pkg::dic_delay_t [dic_pkg::NUM_INPUTS-1:0] act_dly,      // ms
	input  wire dic_pkg::dic_delay_t [dic_pkg::NUM_INPUTS-1:0] drop_dly,     // ms
	input  wire logic [dic_pkg::NUM_INPUTS-1:0]                clr_count,    // clear pulses
	input  wire logic [dic_pkg::NUM_RELAYS-1:0]                relay_ctl,    // relay controls
	output var  logic [dic_pkg::NUM_INPUTS-1:0]                input_status, // status
	output var  dic_pkg::dic_count_t [dic_pkg::NUM_INPUTS-1:0] rise_count,   // counters
	output var  dic_pkg::dic_volt_t [dic_pkg::NUM_INPUTS-1:0]  volt_now,     // voltages
	output var  logic [dic_pkg::NUM_RELAYS-1:0]                relay_out_ff, // relays
	output var  logic                                          scan_tick_ff  // scan pulse
);
	import dic_pkg::*;

	logic [27:0] tick_ff;

	// 5 ms cycle strobe shared by inputs and relays
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			tick_ff      <= 28'h0;
			scan_tick_ff <= 1'b0;
		end
		else if (tick_ff == 28'(SCAN_LEN - 1))
		begin
			tick_ff      <= 28'h0;
			scan_tick_ff <= 1'b1;
		end
		else
		begin
			tick_ff      <= tick_ff + 28'h1;
			scan_tick_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			relay_out_ff <= '0;
		else if (scan_tick_ff)
			relay_out_ff <= relay_ctl;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_INPUTS; g++)
		begin : g_chan
			dic_channel u_chan (
				.clock     (clock),
				.reset     (reset),
				.scan      (scan_tick_ff),
				.volt      (volt_in[g]),
				.nc_pol    (nc_pol[g]),
				.ac_mode   (ac_mode[g]),
				.act_thr   (act_thr[g]),
				.rel_thr   (rel_thr[g]),
				.act_dly   (act_dly[g]),
				.drop_dly  (drop_dly[g]),
				.clr_count (clr_count[g]),
				.status_ff (input_status[g]),
				.count_ff  (rise_count[g]),
				.volt_ff   (volt_now[g])
			);
		end
	endgenerate

	relay_cycle_a: assert property (@(posedge clock) disable iff (reset)
		!$past(scan_tick_ff) |-> $stable(relay_out_ff))
		else $error("relay changed off cycle");
	relay_load_a: assert property (@(posedge clock) disable iff (reset)
		scan_tick_ff |=> relay_out_ff == $past(relay_ctl))
		else $error("relay not refreshed");
	relay_c: cover property (@(posedge clock) scan_tick_ff && relay_ctl != relay_out_ff);
endmodule : dic_top
`default_nettype wire

// ==== tb/dic_field_model.sv ====
// field wiring model: terminal voltages seen by each input channel
`timescale 1ns/100ps
`default_nettype none
module dic_field_model
	import dic_pkg::*;
(
	input  wire logic [NUM_INPUTS-1:0]               energized, // terminal powered
	input  wire dic_pkg::dic_volt_t                  supply_mv, // source level, mV
	output var  dic_pkg::dic_volt_t [NUM_INPUTS-1:0] volt_in    // digitised mV
);
	// a de-energised terminal reads zero volts
	always_comb
	begin
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			volt_in[i] = energized[i] ? supply_mv : '0;
		end
	end
endmodule : dic_field_model
`default_nettype wire

// ==== tb/tb_dic_top.sv ====
// testbench for the digital input conditioner top
`timescale 1ns/100ps
`default_nettype none
module tb_dic_top;
	import dic_pkg::*;
	// shortened scan keeps the run brief; delays count in scans, not clocks
	localparam int unsigned          TB_SCAN   = 20;
	localparam int                   TB_LIMIT  = 2000;
	localparam dic_volt_t            MV_HIGH   = 19'h249f0;	// 150 V
	localparam dic_volt_t            MV_BAND   = 19'h11170;	// 70 V
	localparam dic_volt_t            MV_LOW    = 19'h0c350;	// 50 V
	logic                            clock     = 1'b0;
	logic                            reset     = 1'b1;
	logic [NUM_INPUTS-1:0]           energized = '0;
	dic_volt_t                       supply_mv = 19'h38270;
	dic_volt_t [NUM_INPUTS-1:0]      volt_in;
	logic [NUM_INPUTS-1:0]           nc_pol    = '0;
	logic [NUM_INPUTS-1:0]           ac_mode   = '0;
	dic_thr_t [NUM_INPUTS-1:0]       act_thr   = {NUM_INPUTS{ACT_THR_RST}};
	dic_thr_t [NUM_INPUTS-1:0]       rel_thr   = {NUM_INPUTS{REL_THR_RST}};
	dic_delay_t [NUM_INPUTS-1:0]     act_dly   = {NUM_INPUTS{DELAY_RST}};
	dic_delay_t [NUM_INPUTS-1:0]     drop_dly  = {NUM_INPUTS{DELAY_RST}};
	logic [NUM_INPUTS-1:0]           clr_count = '0;
	logic [NUM_RELAYS-1:0]           relay_ctl = '0;
	logic [NUM_INPUTS-1:0]           input_status;
	dic_count_t [NUM_INPUTS-1:0]     rise_count;
	dic_volt_t [NUM_INPUTS-1:0]      volt_now;
	logic [NUM_RELAYS-1:0]           relay_out_ff;
	logic                            scan_tick_ff;
	int                              fail_count = 0;
	int                              compares   = 0;
	int                              ticks      = 0;
	int                              cycles     = 0;

	always #4 clock = ~clock;

	dic_field_model i_field (.energized(energized), .supply_mv(supply_mv), .volt_in(volt_in));

	dic_top #(.SCAN_LEN(TB_SCAN)) i_dut (
		.clock(clock), .reset(reset), .volt_in(volt_in), .nc_pol(nc_pol), .ac_mode(ac_mode),
		.act_thr(act_thr), .rel_thr(rel_thr), .act_dly(act_dly), .drop_dly(drop_dly),
		.clr_count(clr_count), .relay_ctl(relay_ctl), .input_status(input_status),
		.rise_count(rise_count), .volt_now(volt_now), .relay_out_ff(relay_out_ff),
		.scan_tick_ff(scan_tick_ff)
	);

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
		compares++;
		if (seen !== expected)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, expected, seen);
		end
	endtask : check

	// no scan has run yet, so every output must still be at its reset value
	task automatic idle_check();
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			check("rise_count", rise_count[i], 32'h0);
			check("volt_now", 32'(volt_now[i]), 32'h0);
		end
		check("input_status", 32'(input_status), 32'h0);
		check("relay_out_ff", 32'(relay_out_ff), 32'h0);
		check("scan_tick_ff", 32'(scan_tick_ff), 32'h0);
	endtask : idle_check

	// returns at the falling edge just after the n-th scan has been applied
	task automatic wait_scans(input int n);
		repeat (n)
		begin
			@(negedge clock);
			while (scan_tick_ff !== 1'b1)
				@(negedge clock);
			@(negedge clock);
		end
	endtask : wait_scans

	task automatic check_state(input logic [NUM_INPUTS-1:0] st, input dic_volt_t mv);
		check("input_status", 32'(input_status), 32'(st));
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			check("volt_now", 32'(volt_now[i]), energized[i] ? 32'(mv) : 32'h0);
		end
	endtask : check_state

	// one expected count per channel, one hex digit each, channel 0 lowest
	task automatic check_counts(input logic [NUM_INPUTS-1:0][3:0] expected);
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			check("rise_count", rise_count[i], 32'(expected[i]));
		end
	endtask : check_counts

	always @(posedge clock)
	begin
		cycles++;
		if (scan_tick_ff === 1'b1)
			ticks++;
		if (cycles == TB_LIMIT)
		begin
			fail_count++;
			$display("CHECK FAILED run time expected below %0d cycles seen %0d", TB_LIMIT, cycles);
			summarize();
		end
	end

	initial
	begin
		repeat (2) @(posedge clock);
		@(negedge clock) reset = 1'b0;
		idle_check();
		$display("test reset values done");
		// energise all terminals and set a mix of channel options between scans
		@(negedge clock);
		energized   = '1;
		supply_mv   = MV_HIGH;
		relay_ctl   = 5'h15;
		nc_pol      = 8'h02;
		ac_mode     = 8'h08;
		act_dly[2]  = 21'h00000a;
		drop_dly[4] = 21'h000014;
		act_thr[5]  = 11'h640;
		rel_thr[7]  = 11'h320;
		repeat (TB_SCAN / 2) @(posedge clock);
		@(negedge clock);
		idle_check();
		check("scan ticks", ticks, 32'h0);
		$display("test inputs between scans done");
		wait_scans(1);
		check_state(8'hd9, MV_HIGH);
		check_counts(32'h11011001);
		check("relay_out_ff", 32'(relay_out_ff), 32'h15);
		@(negedge clock) relay_ctl = 5'h0a;
		repeat (2) @(negedge clock);
		check("relay_out_ff", 32'(relay_out_ff), 32'h15);
		wait_scans(1);
		check_state(8'hd9, MV_HIGH);
		check("relay_out_ff", 32'(relay_out_ff), 32'h0a);
		wait_scans(1);
		check_state(8'hdd, MV_HIGH);
		check_counts(32'h11011101);
		$display("test activation done");
		@(negedge clock) supply_mv = MV_BAND;
		wait_scans(1);
		check_state(8'h5d, MV_BAND);
		check_counts(32'h11011101);
		$display("test hysteresis band done");
		@(negedge clock) supply_mv = MV_LOW;
		wait_scans(1);
		check_state(8'h1a, MV_LOW);
		check_counts(32'h11011111);
		wait_scans(3);
		check_state(8'h1a, MV_LOW);
		wait_scans(1);
		check_state(8'h0a, MV_LOW);
		$display("test release done");
		@(negedge clock) energized[3] = 1'b0;
		wait_scans(6);
		check_state(8'h0a, MV_LOW);
		wait_scans(1);
		check_state(8'h02, MV_LOW);
		check_counts(32'h11011111);
		$display("test alternating supply drop done");
		@(negedge clock);
		energized = '1;
		supply_mv = MV_HIGH;
		wait_scans(1);
		check_state(8'hd9, MV_HIGH);
		check_counts(32'h22022112);
		$display("test second rise done");
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			@(negedge clock) clr_count = 8'h01 << i;
			@(negedge clock) clr_count = '0;
			check("cleared count", rise_count[i], 32'h0);
		end
		$display("test counter clear done");
		@(negedge clock) reset = 1'b1;
		repeat (2) @(posedge clock);
		@(negedge clock) reset = 1'b0;
		idle_check();
		wait_scans(1);
		check_state(8'hd9, MV_HIGH);
		check_counts(32'h11011001);
		check("relay_out_ff", 32'(relay_out_ff), 32'h0a);
		$display("test second reset done");
		summarize();
	end
endmodule : tb_dic_top
`default_nettype wire
